// ---- core/prom_tap.sv ----
`timescale 1ns/1ps
`default_nettype none
module prom_tap #(
  parameter logic [31:0] ID_CODE = prom_tap_pkg::ID_CODE_DEFAULT,
  parameter int unsigned BSR_LEN = prom_tap_pkg::BSR_WIDTH
) (
  input  wire logic               sys_clk,
  input  wire logic               rst_n,
  input  wire logic               ce,
  input  wire logic               tck,
  input  wire logic               tms,
  input  wire logic               tdi,
  output var  logic               tdo,
  output var  logic               tdo_oe,
  input  wire logic               in_system_programming,
  input  wire logic               security_set,
  input  wire logic               full_erase_done,
  input  wire logic               user_code_loaded,
  input  wire logic [31:0]        user_code_in,
  input  wire logic               ext_dr_sel,
  input  wire logic               ext_dr_is_read,
  input  wire logic               ext_dr_tdo,
  input  wire logic               prog_reset_req,
  input  wire logic [BSR_LEN-1:0] pin_capture,
  output var  logic [7:0]         instruction,
  output var  logic               dr_capture,
  output var  logic               dr_shift,
  output var  logic               dr_update,
  output var  logic               shift_bit,
  output var  logic               read_inhibit,
  output var  logic               security_flag,
  output var  logic [BSR_LEN-1:0] pin_drive,
  output var  logic               pins_from_bsr,
  output var  logic               pins_hiz,
  output var  logic               config_trigger_n,
  output var  logic               oe_reset_out,
  output var  logic               oe_reset_oe
);

  // ==========================================================
  // Pin synchronisation and clock edges
  // ==========================================================
  logic [2:0] pins_sync;
  logic       tck_s;
  logic       tms_s;
  logic       tdi_s;
  logic       tck_prev_reg;
  logic       tck_rise;
  logic       tck_fall;

  pin_sync #(
    .WIDTH (3)
  ) u_sync (
    .sys_clk  (sys_clk),
    .rst_n    (rst_n),
    .ce       (ce),
    .async_in ({tck, tms, tdi}),
    .sync_out (pins_sync)
  );

  assign tck_s    = pins_sync[2];
  assign tms_s    = pins_sync[1];
  assign tdi_s    = pins_sync[0];
  assign tck_rise = tck_s & ~tck_prev_reg;
  assign tck_fall = ~tck_s & tck_prev_reg;

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      tck_prev_reg <= 1'b0;
    else if (ce)
      tck_prev_reg <= tck_s;
  end

  // ==========================================================
  // TAP controller
  // ==========================================================
  prom_tap_pkg::tap_state_t state_reg;
  prom_tap_pkg::tap_state_t state_next;

  function automatic prom_tap_pkg::tap_state_t tap_step(
    input prom_tap_pkg::tap_state_t s,
    input logic                     m
  );
    case (s)
      prom_tap_pkg::ST_RESET:
        tap_step = m ? prom_tap_pkg::ST_RESET : prom_tap_pkg::ST_IDLE;
      prom_tap_pkg::ST_IDLE:
        tap_step = m ? prom_tap_pkg::ST_SEL_DR : prom_tap_pkg::ST_IDLE;
      prom_tap_pkg::ST_SEL_DR:
        tap_step = m ? prom_tap_pkg::ST_SEL_IR : prom_tap_pkg::ST_CAP_DR;
      prom_tap_pkg::ST_CAP_DR,
      prom_tap_pkg::ST_SH_DR:
        tap_step = m ? prom_tap_pkg::ST_EX1_DR : prom_tap_pkg::ST_SH_DR;
      prom_tap_pkg::ST_EX1_DR:
        tap_step = m ? prom_tap_pkg::ST_UPD_DR : prom_tap_pkg::ST_PA_DR;
      prom_tap_pkg::ST_PA_DR:
        tap_step = m ? prom_tap_pkg::ST_EX2_DR : prom_tap_pkg::ST_PA_DR;
      prom_tap_pkg::ST_EX2_DR:
        tap_step = m ? prom_tap_pkg::ST_UPD_DR : prom_tap_pkg::ST_SH_DR;
      prom_tap_pkg::ST_SEL_IR:
        tap_step = m ? prom_tap_pkg::ST_RESET : prom_tap_pkg::ST_CAP_IR;
      prom_tap_pkg::ST_CAP_IR,
      prom_tap_pkg::ST_SH_IR:
        tap_step = m ? prom_tap_pkg::ST_EX1_IR : prom_tap_pkg::ST_SH_IR;
      prom_tap_pkg::ST_EX1_IR:
        tap_step = m ? prom_tap_pkg::ST_UPD_IR : prom_tap_pkg::ST_PA_IR;
      prom_tap_pkg::ST_PA_IR:
        tap_step = m ? prom_tap_pkg::ST_EX2_IR : prom_tap_pkg::ST_PA_IR;
      prom_tap_pkg::ST_EX2_IR:
        tap_step = m ? prom_tap_pkg::ST_UPD_IR : prom_tap_pkg::ST_SH_IR;
      prom_tap_pkg::ST_UPD_DR,
      prom_tap_pkg::ST_UPD_IR:
        tap_step = m ? prom_tap_pkg::ST_SEL_DR : prom_tap_pkg::ST_IDLE;
      default:
        tap_step = prom_tap_pkg::ST_RESET;
    endcase
  endfunction

  assign state_next = tap_step(state_reg, tms_s);

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      state_reg <= prom_tap_pkg::ST_RESET;
    else if (ce && tck_rise)
      state_reg <= state_next;
  end

  // ==========================================================
  // Instruction register
  // ==========================================================
  logic [7:0] ir_shift_reg;
  logic [7:0] capture_pattern;

  always_comb
  begin
    capture_pattern = prom_tap_pkg::CAP_FIXED;
    capture_pattern[prom_tap_pkg::CAP_STATUS_BIT] =
      in_system_programming;
    capture_pattern[prom_tap_pkg::CAP_SECURITY_BIT] = security_flag;
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      ir_shift_reg <= '0;
    else if (ce && tck_rise)
    begin
      if (state_reg == prom_tap_pkg::ST_CAP_IR)
        ir_shift_reg <= capture_pattern;
      else if (state_reg == prom_tap_pkg::ST_SH_IR)
        ir_shift_reg <= {tdi_s, ir_shift_reg[7:1]};
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      instruction <= prom_tap_pkg::IR_RESET_VALUE;
    else if (ce && tck_rise)
    begin
      if (state_reg == prom_tap_pkg::ST_RESET)
        instruction <= prom_tap_pkg::IR_RESET_VALUE;
      else if (state_reg == prom_tap_pkg::ST_UPD_IR)
        instruction <= ir_shift_reg;
    end
  end

  // ==========================================================
  // Instruction decode
  // ==========================================================
  logic op_extest;
  logic op_sample;
  logic op_clamp;
  logic op_highz;
  logic op_idcode;
  logic op_usercode;
  logic op_bsr;

  assign op_extest   = instruction == prom_tap_pkg::OP_EXTEST;
  assign op_sample   = instruction == prom_tap_pkg::OP_SAMPLE;
  assign op_clamp    = instruction == prom_tap_pkg::OP_CLAMP;
  assign op_highz    = instruction == prom_tap_pkg::OP_HIGHZ;
  assign op_idcode   = instruction == prom_tap_pkg::OP_IDCODE;
  assign op_usercode = instruction == prom_tap_pkg::OP_USERCODE;
  assign op_bsr      = op_extest | op_sample;

  // ==========================================================
  // Read security
  // ==========================================================
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      security_flag <= 1'b0;
    else if (ce)
    begin
      if (security_set)
        security_flag <= 1'b1;
      else if (full_erase_done)
        security_flag <= 1'b0;
    end
  end

  assign read_inhibit = security_flag & ext_dr_is_read;

  // ==========================================================
  // Data registers
  // ==========================================================
  logic               bypass_reg;
  logic [31:0]        id_shift_reg;
  logic [BSR_LEN-1:0] bsr_shift_reg;
  logic               dr_ext;
  logic               dr_id;

  assign dr_ext = ext_dr_sel & ~op_bsr & ~op_idcode & ~op_usercode;
  assign dr_id  = op_idcode | op_usercode;

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      bypass_reg   <= 1'b0;
      id_shift_reg <= '0;
    end
    else if (ce && tck_rise)
    begin
      if (state_reg == prom_tap_pkg::ST_CAP_DR)
      begin
        bypass_reg <= 1'b0;
        if (op_idcode)
          id_shift_reg <= {ID_CODE[31:1], 1'b1};
        else if (user_code_loaded)
          id_shift_reg <= user_code_in;
        else
          id_shift_reg <= prom_tap_pkg::USER_CODE_BLANK;
      end
      else if (state_reg == prom_tap_pkg::ST_SH_DR)
      begin
        bypass_reg   <= tdi_s;
        id_shift_reg <= {tdi_s, id_shift_reg[31:1]};
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      bsr_shift_reg <= '0;
      pin_drive     <= '0;
    end
    else if (ce && tck_rise && op_bsr)
    begin
      if (state_reg == prom_tap_pkg::ST_CAP_DR)
        bsr_shift_reg <= pin_capture;
      else if (state_reg == prom_tap_pkg::ST_SH_DR)
        bsr_shift_reg <= {tdi_s, bsr_shift_reg[BSR_LEN-1:1]};
      else if (state_reg == prom_tap_pkg::ST_UPD_DR)
        pin_drive <= bsr_shift_reg;
    end
  end

  // Strobes to the programming engine, one system cycle each
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      dr_capture <= 1'b0;
      dr_shift   <= 1'b0;
      dr_update  <= 1'b0;
      shift_bit  <= 1'b0;
    end
    else if (ce)
    begin
      dr_capture <= tck_rise & dr_ext &
                    (state_reg == prom_tap_pkg::ST_CAP_DR);
      dr_shift   <= tck_rise & dr_ext &
                    (state_reg == prom_tap_pkg::ST_SH_DR);
      dr_update  <= tck_rise & dr_ext &
                    (state_reg == prom_tap_pkg::ST_UPD_DR);
      if (tck_rise && state_reg == prom_tap_pkg::ST_SH_DR)
        shift_bit <= tdi_s;
    end
  end

  // ==========================================================
  // Test data output, changes on the falling test clock
  // ==========================================================
  logic dr_out_bit;

  always_comb
  begin
    if (op_bsr)
      dr_out_bit = bsr_shift_reg[0];
    else if (dr_id)
      dr_out_bit = id_shift_reg[0];
    else if (dr_ext)
      dr_out_bit = ext_dr_tdo & ~read_inhibit;
    else
      dr_out_bit = bypass_reg;
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tdo    <= 1'b1;
      tdo_oe <= 1'b0;
    end
    else if (ce && tck_fall)
    begin
      tdo_oe <= (state_reg == prom_tap_pkg::ST_SH_IR) ||
                (state_reg == prom_tap_pkg::ST_SH_DR);
      if (state_reg == prom_tap_pkg::ST_SH_IR)
        tdo <= ir_shift_reg[0];
      else if (state_reg == prom_tap_pkg::ST_SH_DR)
        tdo <= dr_out_bit;
      else
        tdo <= 1'b1;
    end
  end

  // ==========================================================
  // Output pin control
  // ==========================================================
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pins_from_bsr <= 1'b0;
      pins_hiz      <= 1'b0;
    end
    else if (ce)
    begin
      pins_from_bsr <= op_extest | op_clamp;
      pins_hiz      <= op_highz |
                       (in_system_programming & ~op_clamp);
    end
  end

  // Open-drain output-enable/reset line
  assign oe_reset_out = 1'b0;

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      oe_reset_oe <= 1'b0;
    else if (ce)
      oe_reset_oe <= prog_reset_req;
  end

  // ==========================================================
  // Configuration trigger pulse
  // ==========================================================
  localparam int unsigned TRIG_W = $clog2(prom_tap_pkg::TRIG_PULSE_CYC + 1);
  localparam logic [TRIG_W-1:0] TRIG_LOAD =
    TRIG_W'(prom_tap_pkg::TRIG_PULSE_CYC);

  logic [TRIG_W-1:0] trig_cnt_reg;

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      trig_cnt_reg <= '0;
    else if (ce)
    begin
      if (tck_rise && state_reg == prom_tap_pkg::ST_UPD_IR &&
          ir_shift_reg == prom_tap_pkg::OP_TRIGGER)
        trig_cnt_reg <= TRIG_LOAD;
      else if (trig_cnt_reg != '0)
        trig_cnt_reg <= trig_cnt_reg - 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      config_trigger_n <= 1'b1;
    else if (ce)
      config_trigger_n <= (trig_cnt_reg == '0);
  end

endmodule
`default_nettype wire

// ---- core/prom_tap_pkg.sv ----
`default_nettype none
package prom_tap_pkg;

  // ==========================================================
  // Register widths
  // ==========================================================
  localparam int unsigned IR_WIDTH  = 8;
  localparam int unsigned ID_WIDTH  = 32;
  localparam int unsigned BSR_WIDTH = 8;

  // ==========================================================
  // Instruction capture pattern fields
  // ==========================================================
  localparam int unsigned CAP_STATUS_BIT   = 4;
  localparam int unsigned CAP_SECURITY_BIT = 3;
  localparam logic [7:0]  CAP_FIXED        = 8'h01;
  localparam logic [7:0]  IR_RESET_VALUE   = 8'hFE;

  // ==========================================================
  // Instruction codes
  // ==========================================================
  localparam logic [7:0] OP_EXTEST   = 8'h00;
  localparam logic [7:0] OP_SAMPLE   = 8'h01;
  localparam logic [7:0] OP_CLAMP    = 8'hFA;
  localparam logic [7:0] OP_HIGHZ    = 8'hFC;
  localparam logic [7:0] OP_USERCODE = 8'hFD;
  localparam logic [7:0] OP_IDCODE   = 8'hFE;
  localparam logic [7:0] OP_BYPASS   = 8'hFF;
  localparam logic [7:0] OP_TRIGGER  = 8'hEE;

  // ==========================================================
  // Identity and user code values
  // ==========================================================
  // Arbitrary neutral value, bit 0 is forced to 1 anyway
  localparam logic [31:0] ID_CODE_DEFAULT = 32'h1234_5671;
  localparam logic [31:0] USER_CODE_BLANK = 32'hFFFF_FFFF;

  // ==========================================================
  // Timing
  // ==========================================================
  localparam int unsigned CLK_PERIOD_NS   = 50;
  localparam int unsigned TRIG_MIN_NS     = 300;
  localparam int unsigned TRIG_MAX_NS     = 500;
  localparam int unsigned TRIG_MIN_CYC    =
    (TRIG_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned TRIG_MAX_CYC    = TRIG_MAX_NS / CLK_PERIOD_NS;
  // One cycle of margin above the least width, still below the most
  localparam int unsigned TRIG_PULSE_CYC  = TRIG_MIN_CYC + 1;

  // ==========================================================
  // TAP controller states
  // ==========================================================
  typedef enum logic [3:0] {
    ST_RESET, ST_IDLE,
    ST_SEL_DR, ST_CAP_DR, ST_SH_DR, ST_EX1_DR, ST_PA_DR, ST_EX2_DR,
    ST_UPD_DR,
    ST_SEL_IR, ST_CAP_IR, ST_SH_IR, ST_EX1_IR, ST_PA_IR, ST_EX2_IR,
    ST_UPD_IR
  } tap_state_t;

endpackage
`default_nettype wire

// ---- core/pin_sync.sv ----
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
  parameter int unsigned WIDTH = 3
) (
  input  wire logic             sys_clk,
  input  wire logic             rst_n,
  input  wire logic             ce,
  input  wire logic [WIDTH-1:0] async_in,
  output var  logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_reg;

  // ==========================================================
  // Two-stage synchroniser
  // ==========================================================
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta_reg <= '0;
      sync_out <= '0;
    end
    else if (ce)
    begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end

endmodule
`default_nettype wire

// ---- tb/prom_tap_props.sv ----
`timescale 1ns/1ps
`default_nettype none
module prom_tap_props (
  input wire logic       sys_clk,
  input wire logic       rst_n,
  input wire logic [7:0] instruction,
  input wire logic       config_trigger_n,
  input wire logic       security_set,
  input wire logic       full_erase_done,
  input wire logic       security_flag,
  input wire logic       ext_dr_is_read,
  input wire logic       read_inhibit,
  input wire logic       prog_reset_req,
  input wire logic       oe_reset_oe,
  input wire logic       oe_reset_out,
  input wire logic       in_system_programming,
  input wire logic       pins_hiz,
  input wire logic       pins_from_bsr
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  // ==========================================================
  // Configuration trigger pulse
  // ==========================================================
  sequence trig_low_s;
    (!config_trigger_n) [*6];
  endsequence
  sequence trig_rest_s;
    config_trigger_n [*8];
  endsequence
  trig_width_a: assert property ($fell(config_trigger_n) |->
    trig_low_s ##[1:5] config_trigger_n) else $error("trigger width");
  trig_cause_a: assert property ($fell(config_trigger_n) |->
    instruction == prom_tap_pkg::OP_TRIGGER) else $error("stray trigger");
  trig_once_a: assert property ($rose(config_trigger_n) |-> trig_rest_s)
    else $error("trigger repeated");

  // ==========================================================
  // Read security
  // ==========================================================
  sec_set_a: assert property (security_set |=> security_flag)
    else $error("security not set");
  sec_keep_a: assert property (security_flag && !full_erase_done |=>
    security_flag) else $error("security lost without erase");
  sec_clear_a: assert property (full_erase_done && !security_set |=>
    !security_flag) else $error("security kept after erase");
  read_block_a: assert property (read_inhibit ==
    (security_flag && ext_dr_is_read)) else $error("read inhibit wrong");

  // ==========================================================
  // Pins and output-enable reset
  // ==========================================================
  oe_reset_a: assert property (prog_reset_req |=>
    oe_reset_oe && !oe_reset_out) else $error("reset line not low");
  isp_safe_a: assert property (in_system_programming [*2] |->
    pins_hiz || pins_from_bsr) else $error("pins live in programming");
  all_hiz_a: assert property (
    (instruction == prom_tap_pkg::OP_HIGHZ) [*2] |-> pins_hiz)
    else $error("highz not applied");
  clamp_hold_a: assert property (
    (instruction == prom_tap_pkg::OP_CLAMP) [*2] |->
    pins_from_bsr && !pins_hiz) else $error("clamp not applied");
endmodule

bind prom_tap prom_tap_props chk (.sys_clk, .rst_n, .instruction,
  .config_trigger_n, .security_set, .full_erase_done, .security_flag,
  .ext_dr_is_read, .read_inhibit, .prog_reset_req, .oe_reset_oe,
  .oe_reset_out, .in_system_programming, .pins_hiz, .pins_from_bsr);
`default_nettype wire

// ---- tb/jtag_host_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module jtag_host_model (
  input  wire logic sys_clk,
  input  wire logic tdo,
  output var  logic tck,
  output var  logic tms,
  output var  logic tdi
);
  // ==========================================================
  // Test clock stands low between frames, data line pulled up
  // ==========================================================
  initial
  begin
    tck = 1'h0;
    tms = 1'h1;
    tdi = 1'h1;
  end

  // One 400 ns test clock period, data sampled while clock is high
  task automatic pulse(input logic m, input logic d, output logic q);
    @(negedge sys_clk);
    tms = m;
    tdi = d;
    repeat (3) @(negedge sys_clk);
    tck = 1'h1;
    repeat (2) @(negedge sys_clk);
    q = tdo;
    repeat (2) @(negedge sys_clk);
    tck = 1'h0;
  endtask

  task automatic reset_tap;
    logic q;
    repeat (5) pulse(1'h1, 1'h1, q);
    pulse(1'h0, 1'h1, q);
  endtask

  // From idle through capture, n shifts LSB first, update, back to idle
  task automatic scan(input logic ir, input int n, input logic [31:0] din,
                      output logic [31:0] dout);
    logic q;
    dout = 32'h0000_0000;
    pulse(1'h1, 1'h1, q);
    if (ir)
      pulse(1'h1, 1'h1, q);
    pulse(1'h0, 1'h1, q);
    pulse(1'h0, 1'h1, q);
    for (int i = 0; i < n; i++)
    begin
      pulse(i == n - 1, din[i], q);
      dout[i] = q;
    end
    pulse(1'h1, 1'h1, q);
    pulse(1'h0, 1'h1, q);
    tdi = 1'h1;
  endtask
endmodule
`default_nettype wire

// ---- tb/prom_tap_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module prom_tap_tb;
  // ==========================================================
  // Signals
  // ==========================================================
  logic        sys_clk = 1'h0, rst_n = 1'h0, ce = 1'h1;
  logic        tck, tms, tdi, tdo, tdo_oe;
  logic        in_system_programming = 1'h0, security_set = 1'h0;
  logic        full_erase_done = 1'h0, user_code_loaded = 1'h0;
  logic        ext_dr_sel = 1'h0, ext_dr_is_read = 1'h0, ext_dr_tdo = 1'h0;
  logic        prog_reset_req = 1'h0, sec_model = 1'h0;
  logic [31:0] user_code_in = 32'h0000_0000, v;
  logic [7:0]  pin_capture = 8'h00, instruction, pin_drive;
  logic        dr_capture, dr_shift, dr_update, shift_bit, read_inhibit;
  logic        security_flag, pins_from_bsr, pins_hiz, config_trigger_n;
  logic        oe_reset_out, oe_reset_oe;
  logic        hiz_e, bsr_e;
  logic [7:0]  cap_n = 8'h00, shf_n = 8'h00, upd_n = 8'h00;
  int          miscompares = 0, check_count = 0, trig_n = 0, trig_cnt = 0;
  string       name_q[$];
  logic [31:0] exp_q[$], seen_q[$];
  logic [7:0]  codes [8];

  always #25 sys_clk = ~sys_clk;

  prom_tap dut (.sys_clk, .rst_n, .ce, .tck, .tms, .tdi, .tdo, .tdo_oe,
    .in_system_programming, .security_set, .full_erase_done,
    .user_code_loaded, .user_code_in, .ext_dr_sel, .ext_dr_is_read,
    .ext_dr_tdo, .prog_reset_req, .pin_capture, .instruction, .dr_capture,
    .dr_shift, .dr_update, .shift_bit, .read_inhibit, .security_flag,
    .pin_drive, .pins_from_bsr, .pins_hiz, .config_trigger_n,
    .oe_reset_out, .oe_reset_oe);
  // Data-out line has a pull-up while the port leaves it undriven
  jtag_host_model host (.sys_clk, .tdo(tdo_oe ? tdo : 1'h1), .tck, .tms,
    .tdi);

  // ==========================================================
  // Checking
  // ==========================================================
  task automatic expect_val(input string nm, input logic [31:0] e);
    name_q.push_back(nm);
    exp_q.push_back(e);
  endtask

  task automatic check(input string nm, input logic [31:0] s,
                       input logic [31:0] e);
    check_count++;
    if (s !== e)
    begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", nm, e, s);
    end
  endtask

  always @(negedge sys_clk)
    while (seen_q.size() > 0)
      check(name_q.pop_front(), seen_q.pop_front(), exp_q.pop_front());

  // Measures every trigger pulse in system clock cycles
  initial forever
  begin
    @(negedge config_trigger_n);
    trig_cnt++;
    trig_n = 0;
    @(negedge sys_clk);
    while (config_trigger_n === 1'h0)
    begin
      trig_n++;
      @(negedge sys_clk);
    end
  end

  // Counts the one-cycle strobes handed to the programming engine
  always @(negedge sys_clk)
  begin
    cap_n = cap_n + 8'(dr_capture === 1'h1);
    shf_n = shf_n + 8'(dr_shift === 1'h1);
    upd_n = upd_n + 8'(dr_update === 1'h1);
  end

  task automatic finish_test;
    if (miscompares == 0 && check_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  initial
  begin
    #1_000_000;
    miscompares++;
    finish_test();
  end

  // ==========================================================
  // Scans
  // ==========================================================
  task automatic ir_scan(input logic [7:0] code);
    logic [7:0]  cap;
    logic [31:0] r;
    cap = {3'h0, in_system_programming, sec_model, 3'h1};
    expect_val("capture", 32'(cap));
    host.scan(1'h1, 8, 32'(code), r);
    seen_q.push_back(r);
    expect_val("instruction", 32'(code));
    seen_q.push_back(32'(instruction));
  endtask

  task automatic dr_scan(input string nm, input int n, input logic [31:0] din,
                         input logic [31:0] e);
    logic [31:0] r;
    expect_val(nm, e);
    host.scan(1'h0, n, din, r);
    seen_q.push_back(r);
  endtask

  initial
  begin
    codes = '{prom_tap_pkg::OP_EXTEST, prom_tap_pkg::OP_SAMPLE,
      prom_tap_pkg::OP_CLAMP, prom_tap_pkg::OP_HIGHZ,
      prom_tap_pkg::OP_USERCODE, prom_tap_pkg::OP_IDCODE,
      prom_tap_pkg::OP_BYPASS, 8'h5A};
    void'($urandom(92));
    repeat (4) @(negedge sys_clk);
    rst_n = 1'h1;
    expect_val("reset code", 32'(prom_tap_pkg::IR_RESET_VALUE));
    seen_q.push_back(32'(instruction));
    host.reset_tap();
    // Every code but the trigger, with security set, set-and-erase together, then erased
    for (int i = 0; i < 8; i++)
    begin
      in_system_programming = 1'($urandom);
      @(negedge sys_clk);
      security_set = (i == 3 || i == 5);
      full_erase_done = (i == 5 || i == 6);
      @(negedge sys_clk);
      security_set = 1'h0;
      full_erase_done = 1'h0;
      sec_model = (i == 3 || i == 5) ? 1'h1 : (i == 6) ? 1'h0 : sec_model;
      ir_scan(codes[i]);
      repeat (2) @(negedge sys_clk);
      hiz_e = (codes[i] == prom_tap_pkg::OP_HIGHZ) ||
              (in_system_programming && codes[i] != prom_tap_pkg::OP_CLAMP);
      bsr_e = codes[i] == prom_tap_pkg::OP_EXTEST ||
              codes[i] == prom_tap_pkg::OP_CLAMP;
      expect_val("pins", {30'h0, hiz_e, bsr_e});
      seen_q.push_back({30'h0, pins_hiz, pins_from_bsr});
    end
    in_system_programming = 1'h0;
    v = $urandom;
    ir_scan(prom_tap_pkg::OP_IDCODE);
    dr_scan("idcode", 32, v,
      prom_tap_pkg::ID_CODE_DEFAULT | 32'h0000_0001);
    ir_scan(prom_tap_pkg::OP_USERCODE);
    dr_scan("blank user", 32, v, 32'hFFFF_FFFF);
    user_code_loaded = 1'h1;
    user_code_in = v;
    dr_scan("user code", 32, ~v, v);
    for (int k = 0; k < 2; k++)
    begin
      ir_scan(k ? 8'h5A : prom_tap_pkg::OP_BYPASS);
      dr_scan("bypass", 8, v, {24'h0, v[6:0], 1'h0});
    end
    pin_capture = v[15:8];
    ir_scan(prom_tap_pkg::OP_SAMPLE);
    dr_scan("sample", 8, v, {24'h0, v[15:8]});
    expect_val("preload", {24'h0, v[7:0]});
    seen_q.push_back({24'h0, pin_drive});
    // Engine read path, open then secured, then a secured program shift
    ext_dr_sel = 1'h1;
    ext_dr_tdo = 1'h1;
    ext_dr_is_read = 1'h1;
    ir_scan(8'h5A);
    dr_scan("open read", 8, v, 32'h0000_00FF);
    security_set = 1'h1;
    @(negedge sys_clk);
    security_set = 1'h0;
    sec_model = 1'h1;
    dr_scan("secured read", 8, v, 32'h0000_0000);
    expect_val("inhibit", 32'h0000_0001);
    seen_q.push_back(32'(read_inhibit));
    ext_dr_is_read = 1'h0;
    dr_scan("secured program", 8, v, 32'h0000_00FF);
    expect_val("strobes", 32'h0003_1803);
    seen_q.push_back({8'h00, cap_n, shf_n, upd_n});
    expect_val("shift bit", {31'h0, v[7]});
    seen_q.push_back({31'h0, shift_bit});
    ext_dr_sel = 1'h0;
    ir_scan(prom_tap_pkg::OP_TRIGGER);
    repeat (20) @(negedge sys_clk);
    expect_val("trigger width", prom_tap_pkg::TRIG_PULSE_CYC);
    seen_q.push_back(trig_n);
    expect_val("trigger count", 32'h0000_0001);
    seen_q.push_back(trig_cnt);
    prog_reset_req = 1'h1;
    repeat (2) @(negedge sys_clk);
    expect_val("oe reset", 32'h0000_0002);
    seen_q.push_back({30'h0, oe_reset_oe, oe_reset_out});
    prog_reset_req = 1'h0;
    repeat (2) @(negedge sys_clk);
    finish_test();
  end
endmodule
`default_nettype wire
